// File: src/srb_sfr_bank.sv
`timescale 1ns/1ps
module srb_sfr_bank #(
   parameter logic PKG_28PIN = 1'b0,
   parameter logic NO_REGULATOR = 1'b0
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // core data-memory access
   input wire logic [11:0] core_addr,
   input wire logic core_rd,
   input wire logic core_wr,
   input wire logic [7:0] core_wdata,
   input wire logic core_access_bank,
   // shared-address view selects
   input wire logic [1:0] ssp_mask_view,
   input wire logic parport_master,
   // reset classes and wake-up
   input wire logic reset_class1,
   input wire logic reset_class2,
   input wire logic wake_event,
   input wire logic wake_by_irq,
   input wire logic wake_high_prio,
   input wire logic [7:0] wake_flags,
   input wire logic [20:0] program_counter,
   // read answer
   output logic [7:0] rd_data_reg,
   output logic rd_valid_reg,
   output logic access_err_reg,
   // indirect alias request to the pointer logic
   output logic indirect_req_reg,
   output logic [1:0] indirect_ptr_reg,
   output logic [2:0] indirect_step_reg,
   // wake-up vector load
   output logic vector_load_reg,
   output logic [20:0] vector_addr_reg
);
   localparam int N = srb_pkg::NREG;

   logic [7:0] reg_q [N];
   logic [7:0] hw_data [N];
   logic [N-1:0] hit;
   logic [N-1:0] sw_we;
   logic [N-1:0] hw_we;
   logic [6:0] view_ok;
   logic [3:0] grp_ok;
   logic in_region;
   logic banked_only;
   logic blocked;
   logic reserved;
   logic go;
   logic ind_hit;
   logic [1:0] ind_ptr;
   logic [2:0] ind_step;
   logic [7:0] rd_mux;
   logic [7:0] int_ctl1;
   logic [7:0] stk_ptr;
   logic wake_push;

   ////////////////////////////////////////////////////////////////////
   // address classification

   // register space runs from the low bound to the top address
   assign in_region = (core_addr >= srb_pkg::LOW_ADDR) &&
                      (core_addr <= srb_pkg::TOP_ADDR);

   // banked-only window cannot be reached by the shortcut
   assign banked_only = (core_addr >= srb_pkg::BANKED_LO) &&
                        (core_addr <= srb_pkg::BANKED_HI);
   assign blocked = core_access_bank && banked_only;

   // reserved holes: writes are dropped, reads give zero
   assign reserved = (core_addr == srb_pkg::RSV_A) ||
                     (core_addr == srb_pkg::RSV_B) ||
                     ((core_addr >= srb_pkg::RSV_LO) &&
                      (core_addr <= srb_pkg::RSV_HI));

   assign go = in_region && !blocked && !reserved;

   // which of the two meanings each shared address shows
   always_comb begin
      view_ok = 7'h00;
      view_ok[srb_pkg::V_ALL] = 1'b1;
      view_ok[srb_pkg::V_SA1] = !ssp_mask_view[0];
      view_ok[srb_pkg::V_SM1] = ssp_mask_view[0];
      view_ok[srb_pkg::V_SA2] = !ssp_mask_view[1];
      view_ok[srb_pkg::V_SM2] = ssp_mask_view[1];
      view_ok[srb_pkg::V_PMA] = parport_master;
      view_ok[srb_pkg::V_PMO] = !parport_master;
   end

   // variant groups that exist on this build
   always_comb begin
      grp_ok = 4'h0;
      grp_ok[srb_pkg::G_CORE] = 1'b1;
      grp_ok[srb_pkg::G_PMP] = !PKG_28PIN;
      grp_ok[srb_pkg::G_DS] = !NO_REGULATOR;
      grp_ok[srb_pkg::G_DSK] = !NO_REGULATOR;
   end

   // indirect aliases: no storage, only a pointer and a step
   always_comb begin
      ind_hit = 1'b0;
      ind_ptr = 2'h0;
      ind_step = 3'h0;
      for (int p = 0; p < srb_pkg::NPTR; p++) begin
         if ((core_addr >= srb_pkg::IND_BASE[p]) &&
             (core_addr <= srb_pkg::IND_BASE[p] + srb_pkg::IND_SPAN)
             && !blocked) begin
            ind_hit = 1'b1;
            ind_ptr = 2'(p);
            ind_step = 3'(core_addr - srb_pkg::IND_BASE[p]);
         end
      end
   end

   // entry match: address, variant, and current view
   always_comb begin
      for (int i = 0; i < N; i++) begin
         hit[i] = go && !ind_hit &&
                  (core_addr == srb_pkg::MAP[i].adr) &&
                  view_ok[srb_pkg::MAP[i].vw] &&
                  grp_ok[srb_pkg::MAP[i].grp];
         sw_we[i] = core_wr && hit[i];
      end
   end

   ////////////////////////////////////////////////////////////////////
   // wake-up side effects

   assign int_ctl1 = reg_q[srb_pkg::IDX_INT_CTL1];
   assign stk_ptr = reg_q[srb_pkg::IDX_STK_PTR];

   // interrupt wake with either global enable set
   assign wake_push = wake_event && wake_by_irq &&
                      (int_ctl1[srb_pkg::HI_EN_BIT] ||
                       int_ctl1[srb_pkg::LO_EN_BIT]);

   // hardware updates; the flag set merges with a core write
   always_comb begin
      for (int i = 0; i < N; i++) begin
         hw_we[i] = 1'b0;
         hw_data[i] = 8'h00;
      end
      if (wake_event) begin
         hw_we[srb_pkg::IDX_INT_CTL1] = 1'b1;
         hw_data[srb_pkg::IDX_INT_CTL1] =
            (sw_we[srb_pkg::IDX_INT_CTL1] ? core_wdata : int_ctl1) |
            (wake_flags & srb_pkg::WAKE_FLAG_MASK);
      end
      if (wake_push) begin
         hw_we[srb_pkg::IDX_STK_L] = 1'b1;
         hw_we[srb_pkg::IDX_STK_H] = 1'b1;
         hw_we[srb_pkg::IDX_STK_U] = 1'b1;
         hw_we[srb_pkg::IDX_STK_PTR] = 1'b1;
         hw_data[srb_pkg::IDX_STK_L] = program_counter[7:0];
         hw_data[srb_pkg::IDX_STK_H] = program_counter[15:8];
         hw_data[srb_pkg::IDX_STK_U] =
            8'(program_counter[20:16]);
         hw_data[srb_pkg::IDX_STK_PTR] =
            (stk_ptr & ~srb_pkg::STK_PTR_MASK) |
            ((stk_ptr + 8'h01) & srb_pkg::STK_PTR_MASK);
      end
   end

   ////////////////////////////////////////////////////////////////////
   // register storage

   // one cell per entry; wake by watchdog sets only the cause flags in int_ctl1
   for (genvar g = 0; g < N; g++) begin : g_cell
      localparam logic [7:0] K1 =
         (srb_pkg::MAP[g].grp == srb_pkg::G_DSK) ?
         srb_pkg::KEEP_ALL : srb_pkg::KEEP_NONE;
      srb_cell #(
         .RST1(srb_pkg::MAP[g].r1),
         .KEEP1(K1),
         .RST2(srb_pkg::MAP[g].r2),
         .KEEP2(srb_pkg::MAP[g].k2),
         .IMPL(srb_pkg::MAP[g].im)
      ) u_cell (
         .clk(clk),
         .rst_n(rst_n),
         .clr1(reset_class1),
         .clr2(reset_class2),
         .sw_we(sw_we[g]),
         .sw_data(core_wdata),
         .hw_we(hw_we[g]),
         .hw_data(hw_data[g]),
         .q(reg_q[g])
      );
   end

   ////////////////////////////////////////////////////////////////////
   // read path

   // unmatched addresses leave the mux at zero
   always_comb begin
      rd_mux = 8'h00;
      for (int i = 0; i < N; i++) begin
         if (hit[i] && (i != srb_pkg::IDX_UNLOCK)) begin
            rd_mux = rd_mux | (reg_q[i] & srb_pkg::MAP[i].im);
         end
      end
   end

   // read data, answered one cycle after the request
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_data_reg <= 8'h00;
         rd_valid_reg <= 1'b0;
      end else begin
         rd_valid_reg <= core_rd;
         if (core_rd) begin
            rd_data_reg <= rd_mux;
         end
      end
   end

   // error pulse for shortcut misuse or a reserved write
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         access_err_reg <= 1'b0;
      end else begin
         access_err_reg <= ((core_rd || core_wr) && blocked) ||
                           (core_wr && reserved);
      end
   end

   // alias request handed to the pointer logic
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         indirect_req_reg <= 1'b0;
         indirect_ptr_reg <= 2'h0;
         indirect_step_reg <= 3'h0;
      end else begin
         indirect_req_reg <= (core_rd || core_wr) && ind_hit;
         if (ind_hit) begin
            indirect_ptr_reg <= ind_ptr;
            indirect_step_reg <= ind_step;
         end
      end
   end

   // vector load toward the program counter
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         vector_load_reg <= 1'b0;
         vector_addr_reg <= 21'h000000;
      end else begin
         vector_load_reg <= wake_push;
         if (wake_push) begin
            vector_addr_reg <= wake_high_prio ?
               srb_pkg::VEC_HIGH : srb_pkg::VEC_LOW;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   logic quiet;
   assign quiet = !reset_class1 && !reset_class2;

   chk_rd_unmapped_zero: assert property (
      core_rd && !(|hit) |=> rd_valid_reg && (rd_data_reg == 8'h00))
      else $error("unmapped read not zero");

   chk_banked_shortcut_block: assert property (
      core_rd && core_access_bank &&
      (core_addr >= srb_pkg::BANKED_LO) &&
      (core_addr <= srb_pkg::BANKED_HI)
      |=> (rd_data_reg == 8'h00) && access_err_reg)
      else $error("shortcut reached banked-only register");

   chk_shared_addr_view: assert property (
      core_rd && quiet && !ssp_mask_view[0] &&
      (core_addr == srb_pkg::MAP[srb_pkg::IDX_SSP1_ADR].adr)
      |=> rd_data_reg == $past(reg_q[srb_pkg::IDX_SSP1_ADR]))
      else $error("shared address shows wrong register");

   chk_indirect_no_store: assert property (
      core_rd && ind_hit |=> indirect_req_reg &&
      (rd_data_reg == 8'h00) && (indirect_ptr_reg == $past(ind_ptr)))
      else $error("indirect alias misbehaved");

   chk_wake_stack_push: assert property (
      wake_push && quiet |=>
      (reg_q[srb_pkg::IDX_STK_L] == $past(program_counter[7:0])) &&
      (reg_q[srb_pkg::IDX_STK_H] == $past(program_counter[15:8])) &&
      ((reg_q[srb_pkg::IDX_STK_PTR] & srb_pkg::STK_PTR_MASK) ==
       (($past(stk_ptr) + 8'h01) & srb_pkg::STK_PTR_MASK)))
      else $error("wake push of counter wrong");

   chk_wake_vector_load: assert property (
      wake_push |=> vector_load_reg &&
      (vector_addr_reg == ($past(wake_high_prio) ?
                           srb_pkg::VEC_HIGH : srb_pkg::VEC_LOW))
      ##1 !vector_load_reg || $past(wake_push))
      else $error("wake vector wrong");

   chk_wake_flag_set: assert property (
      wake_event && quiet |=>
      ((int_ctl1 & $past(wake_flags & srb_pkg::WAKE_FLAG_MASK)) ==
       $past(wake_flags & srb_pkg::WAKE_FLAG_MASK)))
      else $error("wake cause flag lost");

   chk_class1_values: assert property (
      reset_class1 |=> (reg_q[srb_pkg::IDX_CMP_REF] == 8'h00) &&
      (reg_q[srb_pkg::IDX_REMAP24] == 8'h1f))
      else $error("class-1 reset value wrong");

   chk_class2_keeps: assert property (
      reset_class2 && !reset_class1 |=>
      $stable(reg_q[srb_pkg::IDX_CAL_TRIM]) &&
      (reg_q[srb_pkg::IDX_AN_SEL0] == 8'h00))
      else $error("class-2 reset value wrong");

   chk_wake_keeps_regs: assert property (
      wake_event && quiet && !core_wr |=>
      $stable(reg_q[srb_pkg::IDX_AN_SEL0]) &&
      $stable(reg_q[srb_pkg::IDX_CAL_TRIM]))
      else $error("wake changed a register");

   chk_unimpl_bits_zero: assert property (
      core_wr && quiet |=> (reg_q[srb_pkg::IDX_AN_SEL1] &
      ~srb_pkg::MAP[srb_pkg::IDX_AN_SEL1].im) == 8'h00)
      else $error("unimplemented bit stored");

   chk_no_regulator_absent: assert property (
      NO_REGULATOR && core_rd &&
      (core_addr == srb_pkg::MAP[srb_pkg::IDX_DS_CTL_H].adr)
      |=> rd_data_reg == 8'h00)
      else $error("deep-sleep register visible");

   chk_small_pkg_absent: assert property (
      PKG_28PIN && core_rd &&
      (core_addr == srb_pkg::MAP[srb_pkg::IDX_PMA_H].adr)
      |=> rd_data_reg == 8'h00)
      else $error("parallel port register visible");

   chk_read_one_cycle: assert property (
      core_rd |=> rd_valid_reg ##1 (rd_valid_reg == $past(core_rd)))
      else $error("read answer late");

   cov_wake_push: cover property (wake_push ##1 vector_load_reg);
   cov_shortcut_block: cover property (core_rd && blocked);
   cov_class2_reset: cover property (reset_class2);
   cov_indirect: cover property (core_wr && ind_hit);
endmodule : srb_sfr_bank

// File: common/srb_pkg.sv
// What this block does
// - decode registers from top address down to bound
// - unmapped register addresses read as zero
// - banked-only range refuses the access-bank shortcut
// - serial address and mask share one location
// - parallel address and output share, mode selects
// - indirect entries are aliases without storage
// - interrupt wake pushes counter, advances stack pointer
// - interrupt wake loads high or low vector
// - wake leaves a cause flag set
// - power-on class loads first-class values
// - soft reset class loads second-class values
// - watchdog or interrupt wake keeps registers other than cause flags and stack
// - unimplemented bits read zero, ignore writes
// - no deep-sleep registers without core regulator
// - no parallel port registers on 28-pin variant
package srb_pkg;
   // decode window
   localparam logic [11:0] TOP_ADDR = 12'hfff;
   localparam logic [11:0] LOW_ADDR = 12'hf40;
   localparam logic [11:0] BANKED_LO = 12'hec0;
   localparam logic [11:0] BANKED_HI = 12'hf5f;
   // reserved locations
   localparam logic [11:0] RSV_A = 12'hfd4;
   localparam logic [11:0] RSV_B = 12'hf87;
   localparam logic [11:0] RSV_LO = 12'hf60;
   localparam logic [11:0] RSV_HI = 12'hf65;
   // indirect alias groups, one per pointer pair
   localparam int NPTR = 3;
   localparam logic [11:0] IND_BASE [NPTR] = '{12'hfeb, 12'hfe3, 12'hfdb};
   localparam logic [11:0] IND_SPAN = 12'h004;
   // wake-up vectors and control bits
   localparam logic [20:0] VEC_HIGH = 21'h000008;
   localparam logic [20:0] VEC_LOW = 21'h000018;
   localparam int HI_EN_BIT = 7;
   localparam int LO_EN_BIT = 6;
   localparam logic [7:0] WAKE_FLAG_MASK = 8'h07;
   localparam logic [7:0] STK_PTR_MASK = 8'h1f;
   localparam logic [7:0] KEEP_ALL = 8'hff;
   localparam logic [7:0] KEEP_NONE = 8'h00;
   // register groups
   localparam logic [1:0] G_CORE = 2'h0;
   localparam logic [1:0] G_PMP = 2'h1;
   localparam logic [1:0] G_DS = 2'h2;
   localparam logic [1:0] G_DSK = 2'h3;
   // views of shared addresses
   localparam logic [2:0] V_ALL = 3'h0;
   localparam logic [2:0] V_SA1 = 3'h1;
   localparam logic [2:0] V_SM1 = 3'h2;
   localparam logic [2:0] V_SA2 = 3'h3;
   localparam logic [2:0] V_SM2 = 3'h4;
   localparam logic [2:0] V_PMA = 3'h5;
   localparam logic [2:0] V_PMO = 3'h6;
   typedef struct packed {
      logic [11:0] adr;
      logic [7:0] r1;
      logic [7:0] r2;
      logic [7:0] k2;
      logic [7:0] im;
      logic [1:0] grp;
      logic [2:0] vw;
   } srb_entry_t;
   localparam int NREG = 56;
   // address, class-1 value, class-2 value, class-2 keep, implemented
   localparam srb_entry_t MAP [NREG] = '{
      '{12'hfa6, 8'h00, 8'h00, 8'h00, 8'hff, G_CORE, V_ALL},
      '{12'hfa7, 8'h00, 8'h00, 8'h00, 8'hff, G_CORE, V_ALL},
      '{12'hfc0, 8'h00, 8'h00, 8'h00, 8'hff, G_CORE, V_ALL},
      '{12'hfd0, 8'h00, 8'h00, 8'h00, 8'hff, G_CORE, V_ALL},
      '{12'hfd8, 8'h00, 8'h00, 8'h00, 8'hff, G_CORE, V_ALL},
      '{12'hfe0, 8'h00, 8'h00, 8'h00, 8'hff, G_CORE, V_ALL},
      '{12'hfe8, 8'h00, 8'h00, 8'h00, 8'hff, G_CORE, V_ALL},
      '{12'hff0, 8'h00, 8'h00, 8'h00, 8'hff, G_CORE, V_ALL},
      '{12'hff1, 8'h00, 8'h00, 8'h00, 8'hff, G_CORE, V_ALL},
      '{12'hff2, 8'h00, 8'h00, 8'h00, 8'hff, G_CORE, V_ALL},
      '{12'hff9, 8'h00, 8'h00, 8'h00, 8'hff, G_CORE, V_ALL},
      '{12'hffa, 8'h00, 8'h00, 8'h00, 8'hff, G_CORE, V_ALL},
      '{12'hffb, 8'h00, 8'h00, 8'h00, 8'hff, G_CORE, V_ALL},
      '{12'hffc, 8'h00, 8'h00, 8'h00, 8'hff, G_CORE, V_ALL},
      '{12'hffd, 8'h00, 8'h00, 8'h00, 8'hff, G_CORE, V_ALL},
      '{12'hffe, 8'h00, 8'h00, 8'h00, 8'hff, G_CORE, V_ALL},
      '{12'hfff, 8'h00, 8'h00, 8'h00, 8'hff, G_CORE, V_ALL},
      '{12'hfc8, 8'h00, 8'h00, 8'h00, 8'hff, G_CORE, V_SA1},
      '{12'hfc8, 8'h00, 8'h00, 8'h00, 8'hff, G_CORE, V_SM1},
      '{12'hf74, 8'h00, 8'h00, 8'h00, 8'hff, G_CORE, V_SA2},
      '{12'hf74, 8'h00, 8'h00, 8'h00, 8'hff, G_CORE, V_SM2},
      '{12'hf6f, 8'h00, 8'h00, 8'h00, 8'hff, G_PMP, V_PMA},
      '{12'hf6e, 8'h00, 8'h00, 8'h00, 8'hff, G_PMP, V_PMA},
      '{12'hf6f, 8'h00, 8'h00, 8'h00, 8'hff, G_PMP, V_PMO},
      '{12'hf6e, 8'h00, 8'h00, 8'h00, 8'hff, G_PMP, V_PMO},
      '{12'hf40, 8'h00, 8'h00, 8'h00, 8'hff, G_PMP, V_ALL},
      '{12'hf41, 8'h00, 8'h00, 8'h00, 8'hff, G_PMP, V_ALL},
      '{12'hf42, 8'h00, 8'h00, 8'h00, 8'hff, G_PMP, V_ALL},
      '{12'hf43, 8'h00, 8'h00, 8'h00, 8'hff, G_PMP, V_ALL},
      '{12'hf44, 8'h00, 8'h00, 8'h00, 8'hff, G_PMP, V_ALL},
      '{12'hf45, 8'h00, 8'h00, 8'h00, 8'hff, G_PMP, V_ALL},
      '{12'hf46, 8'h00, 8'h00, 8'h00, 8'hcf, G_PMP, V_ALL},
      '{12'hf47, 8'h8f, 8'h8f, 8'h00, 8'hcf, G_PMP, V_ALL},
      '{12'hf48, 8'h00, 8'h00, 8'h00, 8'hff, G_CORE, V_ALL},
      '{12'hf49, 8'h00, 8'h00, 8'h03, 8'h13, G_CORE, V_ALL},
      '{12'hf4a, 8'h00, 8'h00, 8'hff, 8'hff, G_DSK, V_ALL},
      '{12'hf4b, 8'h00, 8'h00, 8'hff, 8'hff, G_DSK, V_ALL},
      '{12'hf4c, 8'h00, 8'h00, 8'h07, 8'h87, G_DS, V_ALL},
      '{12'hf4d, 8'h00, 8'h00, 8'h04, 8'h07, G_DS, V_ALL},
      '{12'hf4e, 8'h00, 8'h00, 8'h00, 8'h01, G_DS, V_ALL},
      '{12'hf4f, 8'h01, 8'h00, 8'h00, 8'hdd, G_DS, V_ALL},
      '{12'hf50, 8'h00, 8'h00, 8'h00, 8'hdf, G_CORE, V_ALL},
      '{12'hf51, 8'h00, 8'h00, 8'h00, 8'hff, G_CORE, V_ALL},
      '{12'hf52, 8'h00, 8'h00, 8'h03, 8'h03, G_CORE, V_ALL},
      '{12'hf53, 8'h00, 8'h00, 8'h03, 8'h03, G_CORE, V_ALL},
      '{12'hf54, 8'h00, 8'h00, 8'h03, 8'h03, G_CORE, V_ALL},
      '{12'hf55, 8'h00, 8'h00, 8'hbf, 8'hbf, G_CORE, V_ALL},
      '{12'hf56, 8'h00, 8'h00, 8'hff, 8'hff, G_CORE, V_ALL},
      '{12'hf57, 8'h00, 8'h00, 8'h00, 8'hbf, G_CORE, V_ALL},
      '{12'hf58, 8'h00, 8'h00, 8'h00, 8'h07, G_CORE, V_ALL},
      '{12'hf59, 8'h00, 8'h00, 8'h00, 8'h01, G_CORE, V_ALL},
      '{12'hf5a, 8'h1f, 8'h1f, 8'h00, 8'h1f, G_CORE, V_ALL},
      '{12'hf5b, 8'h1f, 8'h1f, 8'h00, 8'h1f, G_CORE, V_ALL},
      '{12'hf5c, 8'h1f, 8'h1f, 8'h00, 8'h1f, G_CORE, V_ALL},
      '{12'hf5d, 8'h1f, 8'h1f, 8'h00, 8'h1f, G_CORE, V_ALL},
      '{12'hf5e, 8'h1f, 8'h1f, 8'h00, 8'h1f, G_CORE, V_ALL}
   };
   // indices of entries the logic touches
   localparam int IDX_UNLOCK = 1;
   localparam int IDX_INT_CTL1 = 9;
   localparam int IDX_STK_PTR = 13;
   localparam int IDX_STK_L = 14;
   localparam int IDX_STK_H = 15;
   localparam int IDX_STK_U = 16;
   localparam int IDX_SSP1_ADR = 17;
   localparam int IDX_PMA_H = 21;
   localparam int IDX_CMP_REF = 33;
   localparam int IDX_DS_CTL_H = 37;
   localparam int IDX_AN_SEL1 = 41;
   localparam int IDX_AN_SEL0 = 42;
   localparam int IDX_CAL_TRIM = 47;
   localparam int IDX_REMAP24 = 51;
endpackage : srb_pkg

// File: src/srb_cell.sv
`timescale 1ns/1ps
module srb_cell #(
   parameter logic [7:0] RST1 = 8'h00,
   parameter logic [7:0] KEEP1 = 8'h00,
   parameter logic [7:0] RST2 = 8'h00,
   parameter logic [7:0] KEEP2 = 8'h00,
   parameter logic [7:0] IMPL = 8'hff
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // reset classes
   input wire logic clr1,
   input wire logic clr2,
   // core write
   input wire logic sw_we,
   input wire logic [7:0] sw_data,
   // hardware update, wins over the core write
   input wire logic hw_we,
   input wire logic [7:0] hw_data,
   // stored value
   output logic [7:0] q
);
   // one register: class-1 reset, class-2 reset, hardware, core
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= RST1 & IMPL;
      end else if (clr1) begin
         q <= ((RST1 & ~KEEP1) | (q & KEEP1)) & IMPL;
      end else if (clr2) begin
         q <= ((RST2 & ~KEEP2) | (q & KEEP2)) & IMPL;
      end else if (hw_we) begin
         q <= hw_data & IMPL;
      end else if (sw_we) begin
         q <= sw_data & IMPL;
      end
   end
endmodule : srb_cell

// File: test/srb_core_model.sv
`timescale 1ns/1ps
module srb_core_model (
   // clock
   input wire logic clk,
   // core request
   output logic [11:0] core_addr,
   output logic core_rd,
   output logic core_wr,
   output logic [7:0] core_wdata,
   output logic core_access_bank,
   // read answer
   input wire logic [7:0] rd_data_reg
);
   ////////////////////////////////////////////////////////////
   // bus idle at time zero, no strobe
   initial begin
      core_addr = 12'h000;
      core_rd = 1'b0;
      core_wr = 1'b0;
      core_wdata = 8'h00;
      core_access_bank = 1'b0;
   end
   // one write pulse; only the places the bench names are written
   task automatic wr(input logic [11:0] a, input logic [7:0] d,
                     input logic ab);
      @(posedge clk) #1;
      core_addr = a;
      core_wdata = d;
      core_access_bank = ab;
      core_wr = 1'b1;
      @(posedge clk) #1;
      core_wr = 1'b0;
      core_addr = ~a;
      core_wdata = ~d;
   endtask : wr
   // one read pulse; data taken once the answer edge has landed
   task automatic rd(input logic [11:0] a, input logic ab,
                     output logic [7:0] d);
      @(posedge clk) #1;
      core_addr = a;
      core_access_bank = ab;
      core_rd = 1'b1;
      @(posedge clk) #1;
      d = rd_data_reg;
      core_rd = 1'b0;
      core_addr = ~a;
   endtask : rd
endmodule : srb_core_model

// File: test/sfr_map_reset_init_test.sv
`timescale 1ns/1ps
module sfr_map_reset_init_test;
   logic clk, rst_n, rd_valid_reg, access_err_reg, indirect_req_reg;
   logic vector_load_reg, parport_master, core_rd, core_wr, core_access_bank;
   logic reset_class1, reset_class2, wake_event, wake_by_irq, wake_high_prio;
   logic [1:0] ssp_mask_view, indirect_ptr_reg;
   logic [2:0] indirect_step_reg;
   logic [7:0] core_wdata, wake_flags, rd_data_reg, small_rd, got;
   logic [11:0] core_addr;
   logic [20:0] program_counter, vector_addr_reg;
   int miscompares = 0;
   int comparisons = 0;
   ////////////////////////////////////////////////////////////
   // full variant, and a 28-pin variant without regulator
   srb_sfr_bank u_srb_sfr_bank (.*);
   srb_sfr_bank #(.PKG_28PIN(1'b1), .NO_REGULATOR(1'b1)) u_srb_sfr_bank_small (
      .clk(clk), .rst_n(rst_n), .core_addr(core_addr), .core_rd(core_rd),
      .core_wr(core_wr), .core_wdata(core_wdata),
      .core_access_bank(core_access_bank), .ssp_mask_view(ssp_mask_view),
      .parport_master(parport_master), .reset_class1(reset_class1),
      .reset_class2(reset_class2), .wake_event(wake_event),
      .wake_by_irq(wake_by_irq), .wake_high_prio(wake_high_prio),
      .wake_flags(wake_flags), .program_counter(program_counter),
      .rd_data_reg(small_rd), .rd_valid_reg(), .access_err_reg(),
      .indirect_req_reg(), .indirect_ptr_reg(), .indirect_step_reg(),
      .vector_load_reg(), .vector_addr_reg());
   srb_core_model u_srb_core_model (.clk(clk), .core_addr(core_addr),
      .core_rd(core_rd), .core_wr(core_wr), .core_wdata(core_wdata),
      .core_access_bank(core_access_bank), .rd_data_reg(rd_data_reg));
   ////////////////////////////////////////////////////////////
   // 50 MHz clock
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // compare one value and count it
   task automatic check(input logic [21:0] seen, input logic [21:0] exp);
      comparisons++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask : check
   // verdict and end of run
   task automatic complete_run;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : complete_run
   // bus helpers
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      u_srb_core_model.wr(a, d, 1'b0);
   endtask : wr
   task automatic rb(input logic [11:0] a, input logic [7:0] exp);
      u_srb_core_model.rd(a, 1'b0, got);
      check(rd_valid_reg, 1);
      check(got, exp);
   endtask : rb
   // synchronous reset-class pulse
   task automatic pulse_class(input logic two);
      @(posedge clk) #1;
      reset_class1 = ~two;
      reset_class2 = two;
      @(posedge clk) #1;
      reset_class1 = 1'b0;
      reset_class2 = 1'b0;
   endtask : pulse_class
   // wake pulse; returns after the answering edge
   task automatic wake(input logic irq, input logic hi,
                       input logic [7:0] fl, input logic [20:0] pc);
      @(posedge clk) #1;
      wake_event = 1'b1;
      wake_by_irq = irq;
      wake_high_prio = hi;
      wake_flags = fl;
      program_counter = pc;
      @(posedge clk) #1;
      wake_event = 1'b0;
   endtask : wake
   ////////////////////////////////////////////////////////////
   // reset values, unmapped and partial places, variants
   task automatic t_map;
      rb(12'hf5a, 8'h1f);
      rb(12'hf4f, 8'h01);
      rb(12'hf47, 8'h8f);
      wr(12'hff0, 8'h55);
      rb(12'hff0, 8'h55);
      wr(12'hf3f, 8'h5a);
      rb(12'hf3f, 8'h00);
      rb(12'hfd4, 8'h00);
      wr(12'hf49, 8'hff);
      rb(12'hf49, 8'h13);
      wr(12'hf40, 8'ha5);
      rb(12'hf40, 8'ha5);
      check(small_rd, 8'h00);
      wr(12'hf4c, 8'hff);
      rb(12'hf4c, 8'h87);
      check(small_rd, 8'h00);
   endtask : t_map
   // shortcut refused below f60, shared addresses
   task automatic t_bank;
      u_srb_core_model.wr(12'hf48, 8'ha5, 1'b1);
      check(access_err_reg, 1);
      rb(12'hf48, 8'h00);
      wr(12'hf48, 8'h5a);
      u_srb_core_model.rd(12'hf48, 1'b1, got);
      check(got, 8'h00);
      rb(12'hf48, 8'h5a);
      wr(12'hfc8, 8'h11);
      ssp_mask_view = 2'b01;
      wr(12'hfc8, 8'h22);
      rb(12'hfc8, 8'h22);
      ssp_mask_view = 2'b00;
      rb(12'hfc8, 8'h11);
      wr(12'hf74, 8'h66);
      ssp_mask_view = 2'b10;
      wr(12'hf74, 8'h77);
      rb(12'hf74, 8'h77);
      ssp_mask_view = 2'b00;
      rb(12'hf74, 8'h66);
      parport_master = 1'b1;
      wr(12'hf6f, 8'h33);
      parport_master = 1'b0;
      wr(12'hf6f, 8'h44);
      rb(12'hf6f, 8'h44);
      parport_master = 1'b1;
      rb(12'hf6f, 8'h33);
      rb(12'hfef, 8'h00);
      check({indirect_req_reg, indirect_ptr_reg,
             indirect_step_reg}, 6'h24);
      rb(12'hfdd, 8'h00);
      check({indirect_req_reg, indirect_ptr_reg,
             indirect_step_reg}, 6'h32);
   endtask : t_bank
   // reset classes
   task automatic t_class;
      wr(12'hf4a, 8'h77);
      wr(12'hf56, 8'h5c);
      pulse_class(1'b1);
      rb(12'hf49, 8'h03);
      rb(12'hf56, 8'h5c);
      rb(12'hff0, 8'h00);
      pulse_class(1'b0);
      rb(12'hf49, 8'h00);
      rb(12'hf56, 8'h00);
      rb(12'hf4a, 8'h77);
   endtask : t_class
   // interrupt wake, both priorities, and a plain wake
   task automatic t_wake;
      wr(12'hff2, 8'h80);
      wake(1'b1, 1'b1, 8'h00, 21'h012345);
      check({vector_load_reg, vector_addr_reg}, 22'h200008);
      rb(12'hffd, 8'h45);
      rb(12'hffe, 8'h23);
      rb(12'hfff, 8'h01);
      rb(12'hffc, 8'h01);
      wr(12'hff2, 8'h40);
      wr(12'hf56, 8'h3c);
      wake(1'b1, 1'b0, 8'h05, 21'h0abcde);
      check({vector_load_reg, vector_addr_reg}, 22'h200018);
      rb(12'hffc, 8'h02);
      rb(12'hff2, 8'h45);
      wake(1'b0, 1'b0, 8'h02, 21'h000100);
      check(vector_load_reg, 0);
      rb(12'hf56, 8'h3c);
      rb(12'hfff, 8'h0a);
   endtask : t_wake
   ////////////////////////////////////////////////////////////
   // watchdog against a hang
   initial begin
      #200000;
      miscompares++;
      complete_run();
   end
   // main sequence
   initial begin
      {rst_n, reset_class1, reset_class2, wake_event, wake_by_irq} = '0;
      {wake_high_prio, parport_master, ssp_mask_view} = '0;
      wake_flags = 8'h00;
      program_counter = 21'h000000;
      repeat (8) @(posedge clk);
      #1 rst_n = 1'b1;
      t_map();
      t_bank();
      t_class();
      t_wake();
      complete_run();
   end
endmodule : sfr_map_reset_init_test
